/* rtl/instr_fifo.sv */
`include "lsu_defs.svh"

module instr_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction: step

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_valid = (count != '0);
	assign out_data = store[rd_ptr];
	assign next_count = count + {{(CW-1){1'b0}}, push}
		- {{(CW-1){1'b0}}, pop};

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b1;
		end else begin
			if (push)
				wr_ptr <= step(wr_ptr);
			if (pop)
				rd_ptr <= step(rd_ptr);
			count <= next_count;
			// registered so the source sees a clean level, not a decode
			in_ready <= (next_count != CW'(DEPTH));
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push)
			store[wr_ptr] <= in_data;
	end

endmodule: instr_fifo

/* rtl/load_store_transfer_unit.sv */
// Function
// - base read of the program counter gives instruction address plus 8
// - single store of the program counter writes instruction address plus 12
// - late-abort setting updates the base before the trap
// - abort input high makes the unit take the data abort trap
// - load: 1S+1N+1I; load into program counter: 2S+2N+1I
// - single store takes exactly 2N cycles
// - post-indexed with write-back bit forces a non-privileged cycle
// - byte bit set moves one byte, clear moves a word
// - register offset shift amount comes only from the instruction
// - failed condition means no effect
// - block list is 16 bits, bit i selects register i
// - block store of the program counter writes instruction address plus 12
// - block addresses come from base, pre/post bit and up/down bit
// - block registers move in ascending order, program counter last
// - lowest register pairs with lowest block address
// - without write-back base keeps value unless loaded by the block
// - unaligned block addresses still drive their two low bits
// - up bit adds offset, down subtracts; pre bit applies before use
// - post-indexed always writes back; pre-indexed only with write-back bit
// - offset is 12-bit immediate or shifted register
// - block write-back lands at the end of the second cycle
`include "lsu_defs.svh"

module load_store_transfer_unit #(
	parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic instr_valid,
	input lsu_pkg::instr_s instr_in,
	output logic instr_ready,
	input wire logic late_abort,
	input wire logic carry_flag,
	output lsu_pkg::mem_cmd_s mem_cmd,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_abort,
	input wire logic reg_wr_en,
	input wire logic [3:0] reg_wr_idx,
	input wire logic [31:0] reg_wr_data,
	input wire logic [3:0] reg_rd_idx,
	output logic [31:0] reg_rd_data,
	output logic done,
	output logic data_abort
);
	import lsu_pkg::*;

	state_e state;
	instr_s q_data;
	logic q_valid;
	logic [31:0] rf [16];
	logic [31:0] ir, pc_hold, cur_addr, wb_val, orig_base, ld_hold;
	logic wb_en, aborted, pcb;
	logic [15:0] list_left;
	logic [3:0] cur_idx, nx_idx;
	logic [5:0] k;
	logic [31:0] w, d_base, d_off, d_mod, d_span, d_start, d_wbv, nx_data;
	logic f_blk, f_load, f_byte, f_np, d_wben, accept;
	logic [3:0] base_sel, dest_sel, index_sel;
	logic [4:0] d_n;

	function automatic logic [4:0] ones16(input logic [15:0] v);
		logic [4:0] n;
		n = 5'h0;
		for (int i = 0; i < 16; i++) begin
			n = n + {4'h0, v[i]};
		end
		return n;
	endfunction: ones16

	function automatic logic [3:0] lowest(input logic [15:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (v[i])
				r = 4'(i);
		end
		return r;
	endfunction: lowest

	function automatic logic [31:0] reg_pick(input logic [3:0] idx,
		input logic [31:0] v, input logic [31:0] pcv);
		return (idx == `PC_IDX) ? pcv : v;
	endfunction: reg_pick

	// shift amount is always the immediate field, never a register
	function automatic logic [31:0] shift_off(input logic [31:0] v,
		input logic [4:0] a, input logic [1:0] t, input logic c);
		logic [31:0] r;
		case (t)
			2'h0: r = v << a;
			2'h1: r = (a == 5'h0) ? 32'h0 : v >> a;
			2'h2: r = (a == 5'h0) ? {32{v[31]}} : 32'($signed(v) >>> a);
			default: r = (a == 5'h0) ? {c, v[31:1]}
				: (v >> a) | (v << (6'd32 - {1'b0, a}));
		endcase
		return r;
	endfunction: shift_off

	// byte loads zero-extend; word loads rotate the addressed byte low
	function automatic logic [31:0] rot_load(input logic [31:0] d,
		input logic [1:0] a, input logic bsel);
		logic [4:0] sh;
		sh = {a, 3'h0};
		if (bsel)
			return {24'h0, 8'(d >> sh)};
		return (d >> sh) | (d << (6'd32 - {1'b0, sh}));
	endfunction: rot_load

	function automatic mem_cmd_s cmd(input cycle_e c, input logic rq,
		input logic wr, input logic bs, input logic np,
		input logic [31:0] a, input logic [31:0] d);
		mem_cmd_s m;
		m.req = rq;
		m.write = wr;
		m.byte_sel = bs;
		m.nonpriv = np;
		m.cyc = c;
		m.addr = a;
		m.wdata = d;
		return m;
	endfunction: cmd

	function automatic mem_cmd_s idle(input cycle_e c);
		return cmd(c, 1'b0, 1'b0, 1'b0, 1'b0, 32'h0, 32'h0);
	endfunction: idle

	instr_fifo #(
		.WIDTH($bits(instr_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_valid(instr_valid),
		.in_data(instr_in),
		.in_ready(instr_ready),
		.out_valid(q_valid),
		.out_data(q_data),
		.out_ready(state == ST_IDLE)
	);

	assign accept = (state == ST_IDLE) && q_valid;
	assign w = (state == ST_IDLE) ? q_data.word : ir;
	assign f_blk = (w[`F_CLASS] == `CLASS_BLOCK);
	assign f_load = w[`F_LOAD];
	assign f_byte = !f_blk && w[`F_BYTE];
	assign f_np = !f_blk && !w[`F_PRE] && w[`F_WB];
	assign base_sel = w[`F_BASE];
	assign dest_sel = w[`F_DEST];
	assign index_sel = w[`F_INDEX];

	always_comb begin
		d_base = reg_pick(base_sel, rf[base_sel],
			q_data.addr + `PC_READ_OFS);
		d_off = w[`F_IMM] ? shift_off(rf[index_sel], w[`F_SH_AMT],
			w[`F_SH_TYPE], carry_flag) : {20'h0, w[`F_OFS12]};
		d_mod = w[`F_UP] ? d_base + d_off : d_base - d_off;
		d_n = ones16(w[`F_LIST]);
		d_span = {25'h0, d_n, 2'b00};
		d_wben = f_blk ? w[`F_WB] : (!w[`F_PRE] || w[`F_WB]);
		if (f_blk) begin
			// lowest address always pairs with the lowest register
			if (w[`F_UP])
				d_start = w[`F_PRE] ? d_base + `WORD_STEP : d_base;
			else
				d_start = w[`F_PRE] ? d_base - d_span
					: d_base - d_span + `WORD_STEP;
			d_wbv = w[`F_UP] ? d_base + d_span : d_base - d_span;
		end else begin
			d_start = w[`F_PRE] ? d_mod : d_base;
			d_wbv = d_mod;
		end
	end

	always_comb begin
		nx_idx = (state == ST_IDLE)
			? (f_blk ? lowest(w[`F_LIST]) : dest_sel)
			: lowest(list_left);
		nx_data = reg_pick(nx_idx, rf[nx_idx], ((state == ST_IDLE)
			? q_data.addr : pc_hold) + `PC_STORE_OFS);
		// a base stored after the first word already shows its new value
		if (state != ST_IDLE && f_blk && wb_en && nx_idx == base_sel)
			nx_data = wb_val;
		if (f_byte)
			nx_data = {4{nx_data[7:0]}};
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			mem_cmd <= idle(CYC_S);
			done <= 1'b0;
			data_abort <= 1'b0;
		end else begin
			done <= 1'b0;
			data_abort <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (accept && !q_data.cond_pass) begin
						state <= ST_FS2;
						mem_cmd <= idle(CYC_S);
					end else if (accept) begin
						state <= ST_XFER;
						mem_cmd <= cmd(CYC_N, 1'b1, !f_load, f_byte, f_np,
							d_start, nx_data);
					end
				end
				ST_XFER: begin
					if (f_blk && list_left != 16'h0) begin
						mem_cmd <= cmd(CYC_S, 1'b1, !f_load, 1'b0, 1'b0,
							cur_addr + `WORD_STEP, nx_data);
					end else if (f_load) begin
						state <= ST_ICYC;
						mem_cmd <= idle(CYC_I);
					end else begin
						state <= ST_FN;
						mem_cmd <= idle(CYC_N);
					end
				end
				ST_ICYC: begin
					// a program counter load refills the pipeline: N, S, S
					if (pcb && !aborted) begin
						state <= ST_FN;
						mem_cmd <= idle(CYC_N);
					end else begin
						state <= ST_FS2;
						mem_cmd <= idle(CYC_S);
					end
				end
				ST_FN: begin
					if (f_load) begin
						state <= ST_FS1;
						mem_cmd <= idle(CYC_S);
					end else begin
						state <= ST_IDLE;
						mem_cmd <= idle(CYC_S);
						done <= 1'b1;
						data_abort <= aborted;
					end
				end
				ST_FS1: begin
					state <= ST_FS2;
					mem_cmd <= idle(CYC_S);
				end
				ST_FS2: begin
					state <= ST_IDLE;
					mem_cmd <= idle(CYC_S);
					done <= 1'b1;
					data_abort <= aborted;
				end
				default: begin
					state <= ST_IDLE;
					mem_cmd <= idle(CYC_S);
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ir <= 32'h0;
			pc_hold <= 32'h0;
			cur_addr <= 32'h0;
			wb_val <= 32'h0;
			orig_base <= 32'h0;
			ld_hold <= 32'h0;
			wb_en <= 1'b0;
			aborted <= 1'b0;
			pcb <= 1'b0;
			list_left <= 16'h0;
			cur_idx <= 4'h0;
			k <= 6'h0;
		end else if (accept) begin
			ir <= w;
			pc_hold <= q_data.addr;
			cur_addr <= d_start;
			wb_val <= d_wbv;
			orig_base <= d_base;
			wb_en <= d_wben;
			aborted <= 1'b0;
			pcb <= f_load && (f_blk ? w[15] : dest_sel == `PC_IDX);
			list_left <= f_blk ? w[`F_LIST] & ~(16'h1 << nx_idx) : 16'h0;
			cur_idx <= nx_idx;
			k <= 6'h0;
		end else if (state != ST_IDLE) begin
			k <= k + 6'h1;
			if (state == ST_XFER) begin
				if (mem_abort)
					aborted <= 1'b1;
				ld_hold <= rot_load(mem_rdata, mem_cmd.addr[1:0],
					mem_cmd.byte_sel);
				if (f_blk && list_left != 16'h0) begin
					cur_addr <= cur_addr + `WORD_STEP;
					cur_idx <= nx_idx;
					list_left <= list_left & ~(16'h1 << nx_idx);
				end
			end
		end
	end

	// later writes in this block take priority within one edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 16; i++) begin
				rf[i] <= 32'h0;
			end
		end else begin
			if (state == ST_IDLE && reg_wr_en)
				rf[reg_wr_idx] <= reg_wr_data;
			// early abort leaves the base alone; late abort has moved it
			if (state == ST_XFER && !f_blk && wb_en
				&& (late_abort || !mem_abort))
				rf[base_sel] <= wb_val;
			if (state == ST_XFER && f_blk && f_load && !aborted
				&& !mem_abort)
				rf[cur_idx] <= mem_rdata;
			if (state != ST_IDLE && k == 6'h1 && f_blk && wb_en
				&& !(f_load && ir[base_sel]))
				rf[base_sel] <= wb_val;
			if (state == ST_ICYC && !f_blk && !aborted)
				rf[dest_sel] <= ld_hold;
			// an aborted block load must leave the base recoverable
			if (state == ST_ICYC && f_blk && aborted)
				rf[base_sel] <= wb_en ? wb_val : orig_base;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			reg_rd_data <= 32'h0;
		else
			reg_rd_data <= rf[reg_rd_idx];
	end

	logic [31:0] last_addr;
	logic [3:0] last_idx;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			last_addr <= 32'h0;
			last_idx <= 4'h0;
		end else if (mem_cmd.req) begin
			last_addr <= mem_cmd.addr;
			last_idx <= cur_idx;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	str_two_n_a: assert property (
		mem_cmd.req && mem_cmd.write && !f_blk |-> mem_cmd.cyc == CYC_N
		##1 (mem_cmd.cyc == CYC_N && !mem_cmd.req) ##1 done)
		else $error("single store is not 2N");
	ldr_cycles_a: assert property (
		mem_cmd.req && !mem_cmd.write && !f_blk && !pcb
		|-> mem_cmd.cyc == CYC_N ##1 mem_cmd.cyc == CYC_I
		##1 mem_cmd.cyc == CYC_S ##1 done)
		else $error("single load is not 1S+1N+1I");
	ldr_pc_cycles_a: assert property (
		mem_cmd.req && !mem_cmd.write && !f_blk && pcb && !mem_abort
		|=> mem_cmd.cyc == CYC_I ##1 mem_cmd.cyc == CYC_N
		##1 mem_cmd.cyc == CYC_S [*2] ##1 done)
		else $error("counter load is not 2S+2N+1I");
	pc_base_a: assert property (
		accept && q_data.cond_pass && !f_blk && base_sel == `PC_IDX
		&& w[`F_PRE] && w[`F_UP] && !w[`F_IMM]
		|=> mem_cmd.addr == pc_hold + `PC_READ_OFS + {20'h0, ir[11:0]})
		else $error("counter base is not address plus 8");
	pc_store_a: assert property (
		mem_cmd.req && mem_cmd.write && !mem_cmd.byte_sel
		&& cur_idx == `PC_IDX |-> mem_cmd.wdata == pc_hold + `PC_STORE_OFS)
		else $error("stored counter is not address plus 12");
	cond_skip_a: assert property (
		accept && !q_data.cond_pass |=> !mem_cmd.req ##1 done && !data_abort)
		else $error("skipped instruction had an effect");
	block_step_a: assert property (
		mem_cmd.req && f_blk && mem_cmd.cyc == CYC_S
		|-> mem_cmd.addr == last_addr + `WORD_STEP && cur_idx > last_idx)
		else $error("block word out of order");
	block_low_a: assert property (
		mem_cmd.req && f_blk && !ir[`F_UP] && list_left == 16'h0
		|-> mem_cmd.addr == orig_base - (ir[`F_PRE] ? `WORD_STEP : 32'h0))
		else $error("descending block end address wrong");
	nonpriv_a: assert property (
		mem_cmd.req |-> mem_cmd.nonpriv == f_np
		&& mem_cmd.byte_sel == f_byte)
		else $error("cycle attributes wrong");
	block_wb_a: assert property (
		state != ST_IDLE && k == 6'h1 && f_blk && wb_en
		&& !(f_load && ir[base_sel]) |=> rf[base_sel] == wb_val)
		else $error("block write-back not at second cycle");
	abort_trap_a: assert property (
		mem_cmd.req && mem_abort |-> ##[1:24] (done && data_abort))
		else $error("abort did not reach the trap");

	ldm_pc_c: cover property (mem_cmd.req && f_blk && f_load && pcb
		##[1:24] done);
	stm_c: cover property (mem_cmd.req && f_blk && mem_cmd.write
		##1 mem_cmd.req);
	abort_c: cover property (mem_cmd.req && mem_abort ##[1:24] data_abort);
	skip_c: cover property (accept && !q_data.cond_pass);

endmodule: load_store_transfer_unit

/* rtl/lsu_defs.svh */
`ifndef LSU_DEFS_SVH
`define LSU_DEFS_SVH

// instruction word fields
`define F_CLASS 27:25
`define CLASS_BLOCK 3'h4
`define F_IMM 25
`define F_PRE 24
`define F_UP 23
`define F_BYTE 22
`define F_WB 21
`define F_LOAD 20
`define F_BASE 19:16
`define F_DEST 15:12
`define F_LIST 15:0
`define F_OFS12 11:0
`define F_SH_AMT 11:7
`define F_SH_TYPE 6:5
`define F_INDEX 3:0

// program counter views, address stepping and queue depth
`define PC_IDX 4'hf
`define PC_READ_OFS 32'h8
`define PC_STORE_OFS 32'hc
`define WORD_STEP 32'h4
`define FIFO_DEPTH 16

`endif

/* rtl/lsu_pkg.sv */
package lsu_pkg;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_XFER = 6'h02,
		ST_ICYC = 6'h04,
		ST_FN = 6'h08,
		ST_FS1 = 6'h10,
		ST_FS2 = 6'h20
	} state_e;

	typedef enum logic [1:0] {
		CYC_N = 2'h0,
		CYC_S = 2'h1,
		CYC_I = 2'h2
	} cycle_e;

	typedef struct packed {
		logic [31:0] word;
		logic [31:0] addr;
		logic cond_pass;
	} instr_s;

	typedef struct packed {
		logic req;
		logic write;
		logic byte_sel;
		logic nonpriv;
		cycle_e cyc;
		logic [31:0] addr;
		logic [31:0] wdata;
	} mem_cmd_s;

endpackage: lsu_pkg

/* tb/load_store_transfer_unit_tb.sv */
module load_store_transfer_unit_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lsu_pkg::*;

	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic instr_valid = 1'b0, late_abort = 1'b0, carry_flag = 1'b0;
	logic reg_wr_en = 1'b0, abort_en = 1'b0;
	instr_s instr_in = '0;
	logic [3:0] reg_wr_idx = 4'h0, reg_rd_idx = 4'h0;
	logic [31:0] reg_wr_data = 32'h0, abort_addr = 32'h0;
	logic [31:0] reg_rd_data, mem_rdata;
	logic instr_ready, mem_abort, done, data_abort, abt;
	mem_cmd_s mem_cmd;
	int errors = 0, check_count = 0, nn, ns, ni, nx, dcnt = 0;
	logic [31:0] xa [16], xd [16];
	logic xw [16], xnp [16], xb [16];

	load_store_transfer_unit #(.FIFO_DEPTH(16)) u_dut (.clk_sys(clk_sys),
		.rst_n(rst_n), .instr_valid(instr_valid), .instr_in(instr_in),
		.instr_ready(instr_ready), .late_abort(late_abort),
		.carry_flag(carry_flag), .mem_cmd(mem_cmd), .mem_rdata(mem_rdata),
		.mem_abort(mem_abort), .reg_wr_en(reg_wr_en),
		.reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data),
		.reg_rd_idx(reg_rd_idx), .reg_rd_data(reg_rd_data), .done(done),
		.data_abort(data_abort));
	mem_model u_mem (.clk_sys(clk_sys), .rst_n(rst_n), .mem_cmd(mem_cmd),
		.abort_en(abort_en), .abort_addr(abort_addr), .mem_rdata(mem_rdata),
		.mem_abort(mem_abort));

	always #10 clk_sys = ~clk_sys;
	always @(negedge clk_sys) if (done === 1'b1) dcnt++;

	task automatic conclude;
		if (errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask: conclude

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask: chk

	function automatic logic [31:0] sdt(input logic [5:0] f,
		input logic [3:0] rn, input logic [3:0] rd, input logic [11:0] o);
		return {4'he, 2'b01, f, rn, rd, o};
	endfunction: sdt

	function automatic logic [31:0] bdt(input logic [4:0] f,
		input logic [3:0] rn, input logic [15:0] l);
		return {4'he, 3'b100, f, rn, l};
	endfunction: bdt

	task automatic sr(input logic [3:0] i, input logic [31:0] v);
		@(posedge clk_sys);
		reg_wr_en <= 1'b1;
		reg_wr_idx <= i;
		reg_wr_data <= v;
		@(posedge clk_sys);
		reg_wr_en <= 1'b0;
	endtask: sr

	task automatic gr(input logic [3:0] i, output logic [31:0] v);
		@(posedge clk_sys);
		reg_rd_idx <= i;
		@(posedge clk_sys);
		@(negedge clk_sys);
		v = reg_rd_data;
	endtask: gr

	// one instruction through the queue; logs every transfer cycle
	task automatic run(input logic [31:0] w, input logic [31:0] a,
		input logic c);
		int k;
		logic st;
		st = 1'b0;
		nn = 0;
		ns = 0;
		ni = 0;
		nx = 0;
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr_in <= {w, a, c};
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		for (k = 0; k < 100; k++) begin
			@(negedge clk_sys);
			if (done === 1'b1)
				break;
			if (mem_cmd.req === 1'b1 && nx < 16) begin
				st = 1'b1;
				xa[nx] = mem_cmd.addr;
				xd[nx] = mem_cmd.wdata;
				xw[nx] = mem_cmd.write;
				xnp[nx] = mem_cmd.nonpriv;
				xb[nx] = mem_cmd.byte_sel;
				nx++;
			end
			if (st && mem_cmd.cyc === CYC_N) nn++;
			if (st && mem_cmd.cyc === CYC_S) ns++;
			if (st && mem_cmd.cyc === CYC_I) ni++;
		end
		if (k == 100) begin
			errors++;
			conclude();
		end
		abt = data_abort;
	endtask: run

	task automatic sc_single;
		logic [31:0] v;
		sr(4'h1, 32'h100);
		run(sdt(6'b011011, 4'h1, 4'h2, 12'h010), 32'h0, 1'b1);
		chk(xa[0], 32'h110);
		chk(xw[0], 1'b0);
		chk({8'(ns), 8'(nn), 8'(ni)}, 32'h00010101);
		gr(4'h2, v);
		chk(v, 32'h5a5a0110);
		gr(4'h1, v);
		chk(v, 32'h110);
		// post-indexed with the write-back bit: byte, user-level cycle
		sr(4'h3, 32'h2c4);
		run(sdt(6'b000111, 4'h3, 4'h4, 12'h020), 32'h0, 1'b1);
		chk(xa[0], 32'h2c4);
		chk(xnp[0], 1'b1);
		chk(xb[0], 1'b1);
		gr(4'h4, v);
		chk(v, 32'hc4);
		gr(4'h3, v);
		chk(v, 32'h2a4);
		// register offset, shift amount from the instruction, no write-back
		sr(4'h5, 32'h400);
		sr(4'h6, 32'h3);
		run(sdt(6'b110001, 4'h5, 4'h7, 12'h106), 32'h0, 1'b1);
		chk(xa[0], 32'h3f4);
		gr(4'h5, v);
		chk(v, 32'h400);
		// rotate-with-extend offset pulls the carry into bit 31
		sr(4'h6, 32'h4);
		carry_flag <= 1'b1;
		run(sdt(6'b111001, 4'h5, 4'h7, 12'h066), 32'h0, 1'b1);
		chk(xa[0], 32'h80000402);
		sr(4'h8, 32'h500);
		carry_flag <= 1'b0;
		run(sdt(6'b011001, 4'h8, 4'hf, 12'h0), 32'h0, 1'b1);
		chk({8'(ns), 8'(nn), 8'(ni)}, 32'h00020201);
	endtask: sc_single

	task automatic sc_pc_store;
		// pc as base without write-back, pc also the stored register
		run(sdt(6'b011000, 4'hf, 4'hf, 12'h004), 32'h40, 1'b1);
		chk(xa[0], 32'h4c);
		chk(xd[0], 32'h4c);
		chk({8'(nx), 8'(nn), 8'(ns), 8'(ni)}, 32'h01020000);
	endtask: sc_pc_store

	task automatic sc_cond;
		logic [31:0] v;
		sr(4'h9, 32'h600);
		sr(4'ha, 32'h77);
		run(sdt(6'b011011, 4'h9, 4'ha, 12'h004), 32'h0, 1'b0);
		chk(nx, 32'd0);
		gr(4'ha, v);
		chk(v, 32'h77);
		gr(4'h9, v);
		chk(v, 32'h600);
	endtask: sc_cond

	task automatic sc_block;
		logic [31:0] v, s, e [4];
		int m, j;
		e = '{32'h11, 32'h55, 32'h77, 32'h8c};
		for (m = 0; m < 4; m++) begin
			sr(4'h0, 32'h1002);
			sr(4'h1, 32'h11);
			sr(4'h5, 32'h55);
			sr(4'h7, 32'h77);
			run(bdt({m[1], m[0], 3'b010}, 4'h0, 16'h80a2), 32'h80, 1'b1);
			s = m[0] ? (m[1] ? 32'h1006 : 32'h1002) :
				(m[1] ? 32'h0ff2 : 32'h0ff6);
			chk(nx, 32'd4);
			for (j = 0; j < 4; j++) begin
				chk(xa[j], s + 32'h4 * j);
				chk(xd[j], e[j]);
			end
			gr(4'h0, v);
			chk(v, m[0] ? 32'h1012 : 32'h0ff2);
		end
		sr(4'h4, 32'h200);
		run(bdt(5'b10001, 4'h4, 16'h0008), 32'h0, 1'b1);
		gr(4'h4, v);
		chk(v, 32'h200);
		gr(4'h3, v);
		chk(v, 32'h5a5a01fc);
		run(bdt(5'b10001, 4'h4, 16'h0014), 32'h0, 1'b1);
		gr(4'h2, v);
		chk(v, 32'h5a5a01f8);
		gr(4'h4, v);
		chk(v, 32'h5a5a01fc);
	endtask: sc_block

	task automatic sc_abort;
		logic [31:0] v;
		sr(4'h1, 32'h300);
		sr(4'h2, 32'h0);
		abort_en <= 1'b1;
		abort_addr <= 32'h304;
		run(sdt(6'b011011, 4'h1, 4'h2, 12'h004), 32'h0, 1'b1);
		chk(abt, 1'b1);
		gr(4'h2, v);
		chk(v, 32'h0);
		gr(4'h1, v);
		chk(v, 32'h300);
		@(posedge clk_sys);
		late_abort <= 1'b1;
		abort_addr <= 32'h300;
		// immediate index, so base and index never coincide
		run(sdt(6'b001000, 4'h1, 4'h2, 12'h008), 32'h0, 1'b1);
		chk(abt, 1'b1);
		gr(4'h1, v);
		chk(v, 32'h308);
		@(posedge clk_sys);
		abort_en <= 1'b0;
		late_abort <= 1'b0;
	endtask: sc_abort

	task automatic sc_fifo;
		int k, acc, d0;
		acc = 0;
		d0 = dcnt;
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr_in <= {bdt(5'b01000, 4'h0, 16'hffff), 32'h0, 1'b1};
		@(posedge clk_sys);
		instr_in <= {sdt(6'b011001, 4'h0, 4'h1, 12'h0), 32'h0, 1'b0};
		for (k = 0; k < 40; k++) begin
			@(negedge clk_sys);
			if (instr_ready !== 1'b1)
				break;
			acc++;
			@(posedge clk_sys);
		end
		if (k == 40) begin
			errors++;
			conclude();
		end
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		chk(acc, 32'd16);
		for (k = 0; k < 300 && dcnt - d0 < acc + 1; k++)
			@(negedge clk_sys);
		if (k == 300) begin
			errors++;
			conclude();
		end
		chk(dcnt - d0, acc + 1);
		chk(instr_ready, 1'b1);
	endtask: sc_fifo

	initial begin
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		sc_single();
		sc_pc_store();
		sc_cond();
		sc_block();
		sc_abort();
		sc_fifo();
		conclude();
	end
endmodule: load_store_transfer_unit_tb

/* tb/mem_model.sv */
module mem_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input lsu_pkg::mem_cmd_s mem_cmd,
	input wire logic abort_en,
	input wire logic [31:0] abort_addr,
	output logic [31:0] mem_rdata,
	output logic mem_abort
);
	timeunit 1ns;
	timeprecision 1ns;
	import lsu_pkg::*;

	logic [31:0] held;

	// outside a read the data lines flip every cycle so stale data never
	// passes for a real answer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			held <= 32'h0;
		else
			held <= mem_rdata;
	end

	always_comb begin
		if (mem_cmd.req && !mem_cmd.write)
			mem_rdata = mem_cmd.addr ^ 32'h5a5a0000;
		else
			mem_rdata = ~held;
	end

	// the manager refuses one chosen address while enabled
	assign mem_abort = mem_cmd.req && abort_en && mem_cmd.addr == abort_addr;
endmodule: mem_model
